// ===== hdl/dss_pkg.sv
// Package for the debug state sequencer: register map, fields, states.
// Assumes a 32-bit APB master and single-cycle comparator event inputs.
package dss_pkg;

   localparam int          ADDR_W      = 8;
   localparam int          DATA_W      = 32;
   localparam int          CHAN_N      = 3;
   localparam int          SCR_W       = 4;

   localparam logic [7:0]  OFS_CTRL    = 8'h00;
   localparam logic [7:0]  OFS_STATE1_CONTROL    = 8'h04;
   localparam logic [7:0]  OFS_STATE2_CONTROL    = 8'h08;
   localparam logic [7:0]  OFS_STATE3_CONTROL    = 8'h0c;
   localparam logic [7:0]  OFS_STATUS  = 8'h10;

   // Control register, low bits of the word
   typedef struct packed {
      logic [2:0] tagEn;      // Bits 5:3, per channel tag mode
      logic       brkEn;      // Bit 2, breakpoint request enable
      logic       rangePair;  // Bit 1, first and second comparator ranged
      logic       arm;        // Bit 0, sequencer armed
   } dss_ctrl_s;

   localparam int          CTRL_W      = $bits(dss_ctrl_s);
   localparam dss_ctrl_s   CTRL_RST    = '0;
   localparam logic [3:0]  SCR_RST     = 4'h0;

   typedef enum logic [2:0] {
      SEQ_IDLE,
      SEQ_STATE1,
      SEQ_STATE2,
      SEQ_STATE3,
      SEQ_FINAL
   } dss_state_e;

   localparam int          STATE_W     = $bits(dss_state_e);

   // Status register: state in bits 2:0, debug mode in bit 3,
   // last channel that reached the final state in bits 5:4
   typedef struct packed {
      logic [1:0] finalChan;
      logic       bdmActive;
      logic [2:0] seqState;
   } dss_status_s;

   localparam int          STATUS_W    = $bits(dss_status_s);

endpackage

// ===== hdl/debug_state_sequencer.sv
// Debug trigger state sequencer with APB register access.
// Assumes comparator match and tag hit inputs are pulses on ref_clk;
// the debug mode flag is asynchronous and is synchronised here.
//
// Notes on behaviour
// - Three match channels 0,1,2 feed sequencer
// - Four-bit state controls, top bit extends encoding
// - Range pairing disables match channel one
// - Hits leading to final state win first
// - Otherwise lowest-numbered matching channel acts alone
// - Range and data compares belong to channel 0
// - Extended state3: ch0 to state2, ch2 final
// - Extended state1: ch0 goes straight to state3
// - Extended encodings allow per-channel OR forks
// - Channels with equal addresses match independently
// - Legacy state1 code 5: any channel goes to final
// - Tag hit at queue head drives transitions
// - Breakpoint request on entering final state
// - Tagging disabled while background debug active
`timescale 1ns/100ps
`default_nettype none

module dss_debug_state_sequencer
   import dss_pkg::*;
(
   input  wire logic                ref_clk,
   input  wire logic                srst,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic [DATA_W-1:0]   pwdata,
   output logic      [DATA_W-1:0]   prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic [CHAN_N-1:0]   matchHit,
   input  wire logic [CHAN_N-1:0]   tagHit,
   input  wire logic                backgroundDebugMode,
   output logic                     brkReq,
   output logic                     triggered
);

   // Target of one channel from one state, SEQ_IDLE meaning none
   function automatic dss_state_e chanTarget(
      input dss_state_e  st,
      input logic [3:0]  scr,
      input int          ch
   );
      dss_state_e t;
      t = SEQ_IDLE;
      case (st)
         SEQ_STATE1: begin
            case (scr)
               4'h0: if (ch == 0) t = SEQ_STATE2;
               4'h1: if (ch == 1) t = SEQ_STATE2;
               4'h2: if (ch == 2) t = SEQ_STATE2;
               4'h3: if (ch == 1) t = SEQ_STATE3;
               4'h4: if (ch == 2) t = SEQ_STATE3;
               4'h5: t = SEQ_FINAL;
               4'h6: if (ch == 0) t = SEQ_FINAL;
               4'h7: if (ch == 1) t = SEQ_FINAL;
               4'h8: if (ch == 0) t = SEQ_STATE3;
               4'h9: begin
                  if (ch == 0) t = SEQ_STATE3;
                  else if (ch == 1) t = SEQ_FINAL;
                  else t = SEQ_STATE2;
               end
               default: t = SEQ_IDLE;
            endcase
         end
         SEQ_STATE2: begin
            case (scr)
               4'h0: if (ch == 0) t = SEQ_STATE3;
               4'h1: if (ch == 1) t = SEQ_STATE3;
               4'h2: if (ch == 2) t = SEQ_STATE3;
               4'h3: if (ch == 0) t = SEQ_FINAL;
               4'h4: if (ch == 1) t = SEQ_FINAL;
               4'h5: if (ch == 2) t = SEQ_FINAL;
               4'h6: begin
                  if (ch == 1) t = SEQ_STATE1;
                  else if (ch == 2) t = SEQ_FINAL;
               end
               4'h7: begin
                  if (ch == 0) t = SEQ_STATE1;
                  else if (ch == 2) t = SEQ_STATE3;
               end
               4'h8: begin
                  if (ch == 2) t = SEQ_FINAL;
                  else t = SEQ_STATE1;
               end
               default: t = SEQ_IDLE;
            endcase
         end
         SEQ_STATE3: begin
            case (scr)
               4'h0: if (ch == 0) t = SEQ_FINAL;
               4'h1: if (ch == 1) t = SEQ_FINAL;
               4'h2: if (ch == 2) t = SEQ_FINAL;
               4'h3: if (ch == 0) t = SEQ_STATE1;
               4'h4: if (ch == 1) t = SEQ_STATE1;
               4'h5: if (ch == 2) t = SEQ_STATE1;
               4'h6: if (ch == 0) t = SEQ_STATE2;
               4'h7: begin
                  if (ch == 1) t = SEQ_STATE1;
                  else if (ch == 2) t = SEQ_FINAL;
               end
               4'h8: begin
                  if (ch == 0) t = SEQ_STATE2;
                  else if (ch == 2) t = SEQ_FINAL;
               end
               4'h9: begin
                  if (ch == 0) t = SEQ_STATE2;
                  else if (ch == 1) t = SEQ_STATE1;
                  else t = SEQ_FINAL;
               end
               default: t = SEQ_IDLE;
            endcase
         end
         default: t = SEQ_IDLE;
      endcase
      return t;
   endfunction

   // Register state
   dss_ctrl_s            ctrl;
   dss_ctrl_s            next_ctrl;
   logic [SCR_W-1:0]     state1_control;
   logic [SCR_W-1:0]     next_state1_control;
   logic [SCR_W-1:0]     state2_control;
   logic [SCR_W-1:0]     next_state2_control;
   logic [SCR_W-1:0]     state3_control;
   logic [SCR_W-1:0]     next_state3_control;
   logic [DATA_W-1:0]    next_prdata;
   logic                 next_pready;
   logic                 next_pslverr;

   // Sequencer state
   dss_state_e           seq;
   dss_state_e           next_seq;
   logic [1:0]           finalChan;
   logic [1:0]           next_finalChan;
   logic                 next_brkReq;
   logic                 next_triggered;

   // Debug mode synchroniser
   logic                 bdmMeta;
   logic                 bdmSync;

   // Combinational helpers
   logic [CHAN_N-1:0]    chanEvt;
   logic                 wrEn;
   logic                 access;
   logic                 mapped;
   logic [SCR_W-1:0]     curScr;
   dss_state_e           tgt;
   dss_state_e           chanT;
   logic                 gotFinal;
   dss_status_s          status;

   always_comb begin
      // Channel events: tag hit or plain match per channel
      for (int i = 0; i < CHAN_N; i++) begin
         if (ctrl.tagEn[i]) begin
            chanEvt[i] = tagHit[i] & ~bdmSync;
         end else begin
            chanEvt[i] = matchHit[i];
         end
      end
      // Ranged pair lives on channel 0; channel 1 is silenced
      if (ctrl.rangePair) begin
         chanEvt[1] = 1'b0;
      end

      case (seq)
         SEQ_STATE1: curScr = state1_control;
         SEQ_STATE2: curScr = state2_control;
         SEQ_STATE3: curScr = state3_control;
         default:    curScr = SCR_RST;
      endcase

      // Final-state hits first, else lowest channel with a move
      tgt            = SEQ_IDLE;
      chanT          = SEQ_IDLE;
      gotFinal       = 1'b0;
      next_finalChan = finalChan;
      for (int i = CHAN_N - 1; i >= 0; i--) begin
         chanT = chanTarget(seq, curScr, i);
         if (chanEvt[i] && chanT != SEQ_IDLE) begin
            if (chanT == SEQ_FINAL) begin
               gotFinal       = 1'b1;
               next_finalChan = 2'(i);
            end else begin
               tgt = chanT;
            end
         end
      end
      if (gotFinal) begin
         tgt = SEQ_FINAL;
      end

      // Sequencer walk
      next_brkReq = 1'b0;
      case (seq)
         SEQ_IDLE: begin
            next_seq = ctrl.arm ? SEQ_STATE1 : SEQ_IDLE;
         end
         SEQ_STATE1, SEQ_STATE2, SEQ_STATE3: begin
            if (!ctrl.arm) begin
               next_seq = SEQ_IDLE;
            end else if (tgt != SEQ_IDLE) begin
               next_seq    = tgt;
               next_brkReq = (tgt == SEQ_FINAL) & ctrl.brkEn;
            end else begin
               next_seq = seq;
            end
         end
         SEQ_FINAL: begin
            next_seq = ctrl.arm ? SEQ_FINAL : SEQ_IDLE;
         end
         default: next_seq = SEQ_IDLE;
      endcase
      next_triggered = (next_seq == SEQ_FINAL);
   end

   // APB slave: one wait state, then answer
   always_comb begin
      access = psel & penable & ~pready;
      wrEn   = access & pwrite;
      mapped = (paddr == OFS_CTRL) || (paddr == OFS_STATE1_CONTROL) ||
               (paddr == OFS_STATE2_CONTROL) || (paddr == OFS_STATE3_CONTROL) ||
               (paddr == OFS_STATUS);
      status.finalChan = finalChan;
      status.bdmActive = bdmSync;
      status.seqState  = seq;

      next_ctrl           = ctrl;
      next_state1_control = state1_control;
      next_state2_control = state2_control;
      next_state3_control = state3_control;
      next_pready         = access;
      next_pslverr        = access & ~mapped;
      next_prdata         = '0;
      if (wrEn) begin
         case (paddr)
            OFS_CTRL: next_ctrl = dss_ctrl_s'(pwdata[CTRL_W-1:0]);
            OFS_STATE1_CONTROL: next_state1_control = pwdata[SCR_W-1:0];
            OFS_STATE2_CONTROL: next_state2_control = pwdata[SCR_W-1:0];
            OFS_STATE3_CONTROL: next_state3_control = pwdata[SCR_W-1:0];
            default:  next_ctrl = ctrl;
         endcase
      end
      if (access && !pwrite) begin
         case (paddr)
            OFS_CTRL:   next_prdata[CTRL_W-1:0]   = ctrl;
            OFS_STATE1_CONTROL:   next_prdata[SCR_W-1:0]    = state1_control;
            OFS_STATE2_CONTROL:   next_prdata[SCR_W-1:0]    = state2_control;
            OFS_STATE3_CONTROL:   next_prdata[SCR_W-1:0]    = state3_control;
            OFS_STATUS: next_prdata[STATUS_W-1:0] = status;
            default:    next_prdata = '0;
         endcase
      end
   end

   // Debug mode synchroniser, only the second flop is read
   always_ff @(posedge ref_clk) begin
      bdmMeta <= backgroundDebugMode;
      bdmSync <= bdmMeta;
   end

   // Register file and APB answer
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ctrl           <= CTRL_RST;
         state1_control <= SCR_RST;
         state2_control <= SCR_RST;
         state3_control <= SCR_RST;
         prdata         <= '0;
         pready         <= 1'b0;
         pslverr        <= 1'b0;
      end else begin
         ctrl           <= next_ctrl;
         state1_control <= next_state1_control;
         state2_control <= next_state2_control;
         state3_control <= next_state3_control;
         prdata         <= next_prdata;
         pready         <= next_pready;
         pslverr        <= next_pslverr;
      end
   end

   // Sequencer state and trigger outputs
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         seq            <= SEQ_IDLE;
         finalChan      <= '0;
         brkReq         <= 1'b0;
         triggered      <= 1'b0;
      end else begin
         seq            <= next_seq;
         finalChan      <= next_finalChan;
         brkReq         <= next_brkReq;
         triggered      <= next_triggered;
      end
   end

endmodule

`default_nettype wire

// ===== sim/dss_seq_asserts.sv
// Checker for the debug state sequencer top-level ports.
// Assumes the one-wait-state APB slave and event timing of the design.
`timescale 1ns/100ps
`default_nettype none
module dss_seq_asserts
   import dss_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              srst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [DATA_W-1:0] prdata,
   input  wire logic              pready,
   input  wire logic              pslverr,
   input  wire logic [CHAN_N-1:0] matchHit,
   input  wire logic [CHAN_N-1:0] tagHit,
   input  wire logic              brkReq,
   input  wire logic              triggered
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   // Helper terms for sampled-value functions
   logic anyEvt;
   logic wrAcc;
   assign anyEvt = |(matchHit | tagHit);
   assign wrAcc  = psel & penable & pwrite;

   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held over one cycle");
   acc_wait_a: assert property (psel && penable && !pready |=> pready)
      else $error("access not answered after one wait");
   rdata_idle_a: assert property (!pready |-> prdata == '0)
      else $error("read data outside ready");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   brk_pulse_a: assert property (brkReq |=> !brkReq)
      else $error("breakpoint request longer than one cycle");
   brk_on_entry_a: assert property (brkReq |-> $rose(triggered))
      else $error("breakpoint request not at final entry");
   trig_cause_a: assert property (
      $rose(triggered) |-> $past(anyEvt))
      else $error("final state entered without an event");
   final_hold_a: assert property ($fell(triggered) |->
      $past(wrAcc, 2) ||
      $past(wrAcc, 3))
      else $error("final state left without a write");

   cover property ($rose(triggered));
   cover property (brkReq);
   cover property (pslverr);
endmodule
`default_nettype wire

// ===== sim/dss_match_source.sv
// Comparator side model: turns bench requests into event pulses.
// Assumes requests are raised for one cycle on ref_clk.
`timescale 1ns/100ps
`default_nettype none
module dss_match_source
   import dss_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              go,
   input  wire logic [CHAN_N-1:0] evM,
   input  wire logic [CHAN_N-1:0] evT,
   output logic      [CHAN_N-1:0] matchHit,
   output logic      [CHAN_N-1:0] tagHit
);
   // One pulse per channel comparator, quiet between events
   // Channels fire independently even on equal addresses
   always_ff @(posedge ref_clk) begin
      matchHit <= go ? evM : '0;
      tagHit   <= go ? evT : '0;
   end
endmodule
`default_nettype wire

// ===== sim/dss_debug_state_sequencer_bench.sv
// Self-checking bench for the debug state sequencer.
// Assumes the comparator model and checker files are compiled first.
`timescale 1ns/100ps
`default_nettype none
module dss_debug_state_sequencer_bench;
   import dss_pkg::*;
   logic        ref_clk = 1'b0;
   logic        srst    = 1'b1;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [2:0]  matchHit;
   logic [2:0]  tagHit;
   logic [2:0]  evM     = 3'h0;
   logic [2:0]  evT     = 3'h0;
   logic        go      = 1'b0;
   logic        backgroundDebugMode = 1'b0;
   logic        brkReq;
   logic        triggered;
   logic [31:0] rdv;
   logic        errv;
   int          err_count = 0;
   int          compares  = 0;
   int          brkCnt    = 0;

   always #25 ref_clk = ~ref_clk;

   // Counts breakpoint request pulses as they stand
   always @(posedge ref_clk) begin
      if (brkReq === 1'b1) begin
         brkCnt <= brkCnt + 1;
      end
   end

   dss_debug_state_sequencer dut (.ref_clk(ref_clk), .srst(srst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .matchHit(matchHit), .tagHit(tagHit),
      .backgroundDebugMode(backgroundDebugMode), .brkReq(brkReq),
      .triggered(triggered));
   dss_match_source src (.ref_clk(ref_clk), .go(go), .evM(evM),
      .evT(evT), .matchHit(matchHit), .tagHit(tagHit));

   task automatic results();
      $display("compares %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t: got %h, want %h", $time, g, e);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
         err_count++;
         $display("unexpected at %0t: no ready", $time);
         results();
      end
      @(posedge ref_clk);
   endtask

   task automatic ev(input logic [2:0] m, input logic [2:0] t);
      evM <= m;
      evT <= t;
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic stat(input int x);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rdv & 32'h7, x);
   endtask

   task automatic run(input logic [31:0] c, s1, s3, input logic b,
                      input logic [2:0] m1, t1, input int x1,
                      input logic [2:0] m2, t2, input int x2);
      int b0;
      b0 = brkCnt;
      apb(1'b1, OFS_CTRL, 32'h0);
      stat(0);
      backgroundDebugMode <= b;
      apb(1'b1, OFS_STATE1_CONTROL, s1);
      apb(1'b1, OFS_STATE3_CONTROL, s3);
      apb(1'b1, OFS_CTRL, c);
      stat(1);
      ev(m1, t1);
      stat(x1);
      ev(m2, t2);
      stat(x2);
      chk({31'h0, triggered}, x2 == 4);
      chk({31'h0, rdv[3]}, {31'h0, b});
      chk(brkCnt - b0, (c[2] && x2 == 4) ? 32'h1 : 32'h0);
      $display("test done, final state code %0d", x2);
   endtask

   initial begin
      repeat (4) @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(rdv, 32'h0);
      apb(1'b0, OFS_STATE1_CONTROL, 32'h0);
      chk(rdv, 32'h0);
      stat(0);
      apb(1'b0, 8'h14, 32'h0);
      chk({31'h0, errv}, 32'h1);
      apb(1'b1, OFS_STATE2_CONTROL, 32'hfffffff8);
      apb(1'b0, OFS_STATE2_CONTROL, 32'h0);
      chk(rdv, 32'h8);
      run(32'h5,32'h5,32'h0,1'b0,3'h4,3'h0,4,3'h1,3'h0,4);
      chk({30'h0, rdv[5:4]}, 32'h2);
      run(32'h1,32'h8,32'h8,1'b0,3'h1,3'h0,3,3'h5,3'h0,4);
      run(32'h1,32'h9,32'h6,1'b0,3'h5,3'h0,3,3'h1,3'h0,2);
      run(32'h3,32'h7,32'h0,1'b0,3'h2,3'h0,1,3'h3,3'h0,1);
      run(32'h9,32'h6,32'h0,1'b0,3'h0,3'h1,4,3'h0,3'h0,4);
      chk({30'h0, rdv[5:4]}, 32'h0);
      run(32'h1,32'h0,32'h0,1'b0,3'h1,3'h0,2,3'h6,3'h0,4);
      chk({30'h0, rdv[5:4]}, 32'h2);
      run(32'h9,32'h6,32'h0,1'b1,3'h0,3'h1,1,3'h0,3'h1,1);
      results();
   end
endmodule

bind dss_debug_state_sequencer dss_seq_asserts chk_i (.ref_clk(ref_clk),
   .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .matchHit(matchHit), .tagHit(tagHit), .brkReq(brkReq),
   .triggered(triggered));
`default_nettype wire
